// ===== rtl/dls_pkg.sv
package dls_pkg;
  // Register byte offsets
  localparam logic [11:0] VCO_OUTPUT_DIVIDER_ADDR    = 12'h08B;
  localparam logic [11:0] PLL_REFERENCE_DIVIDER_ADDR = 12'h08C;
  localparam logic [11:0] LANE_POWER_DOWN_MASK_ADDR  = 12'h201;
  localparam logic [11:0] CFG_FIRST_ADDR             = 12'h450;
  localparam logic [11:0] CFG_LAST_ADDR              = 12'h45A;
  localparam int          CFG_COUNT                  = 11;
  // Field widths
  localparam int          VCO_DIV_W                  = 2;
  localparam int          REF_DIV_W                  = 3;
  localparam int          LANES                      = 4;
  // Reset values
  localparam logic [7:0]  VCO_DIV_RST                = 8'h00;
  localparam logic [7:0]  REF_DIV_RST                = 8'h00;
  localparam logic [7:0]  LANE_PD_RST                = 8'h00;
  // Feedback count limits
  localparam logic [6:0]  FB_COUNT_MIN               = 7'h06;
  localparam logic [6:0]  FB_COUNT_MAX               = 7'h7F;
  // Interpolation codes
  localparam logic [1:0]  INTERP_1X                  = 2'h0;
  localparam logic [1:0]  INTERP_2X                  = 2'h1;
  localparam logic [1:0]  INTERP_4X                  = 2'h2;
  localparam logic [1:0]  INTERP_8X                  = 2'h3;
  // Single-link modes
  typedef enum logic [3:0] {
    DLS_MODE_4  = 4'h4,
    DLS_MODE_5  = 4'h5,
    DLS_MODE_6  = 4'h6,
    DLS_MODE_7  = 4'h7,
    DLS_MODE_9  = 4'h9,
    DLS_MODE_10 = 4'hA
  } dls_mode_t;
  // Checksum methods
  localparam logic        CKSUM_FIELDS               = 1'b0;
  localparam logic        CKSUM_REGS                 = 1'b1;
  localparam logic [7:0]  N_VALUE                    = 8'h10;
endpackage

// ===== rtl/dls_interp_stage.sv
`timescale 1ns/10ps
// One half-band doubling stage; simple two-tap average for odd samples.
// Inputs queue so a burst from the stage before still yields two outputs each.
module dls_interp_stage (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_data,
  output logic             out_valid,
  output logic [15:0]      out_data
);
  // Depth four covers the 8x burst; faster input than the rules allow overruns it
  logic [15:0] fifo_q [4];
  logic [15:0] fifo_d [4];
  logic [15:0] prev_q, prev_d, out_q, out_d;
  logic [1:0]  head_q, head_d, tail_q, tail_d;
  logic [2:0]  count_q, count_d;
  logic        phase_q, phase_d, out_valid_q, out_valid_d, pop;
  logic [16:0] sum;

  always_comb begin
    sum = {fifo_q[head_q][15], fifo_q[head_q]} + {prev_q[15], prev_q};
    for (int i = 0; i < 4; i++) begin
      fifo_d[i] = fifo_q[i];
    end
    prev_d      = prev_q;
    out_d       = out_q;
    head_d      = head_q;
    tail_d      = tail_q;
    phase_d     = phase_q;
    out_valid_d = 1'b0;
    pop         = 1'b0;
    if (count_q != 3'h0) begin
      out_valid_d = 1'b1;
      if (!phase_q) begin
        out_d   = sum[16:1];
        phase_d = 1'b1;
      end else begin
        out_d   = fifo_q[head_q];
        prev_d  = fifo_q[head_q];
        head_d  = head_q + 2'h1;
        phase_d = 1'b0;
        pop     = 1'b1;
      end
    end
    if (in_valid) begin
      fifo_d[tail_q] = in_data;
      tail_d         = tail_q + 2'h1;
    end
    count_d = count_q + {2'h0, in_valid} - {2'h0, pop};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        fifo_q[i] <= 16'h0000;
      end
      prev_q      <= 16'h0000;
      out_q       <= 16'h0000;
      head_q      <= 2'h0;
      tail_q      <= 2'h0;
      count_q     <= 3'h0;
      phase_q     <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        fifo_q[i] <= fifo_d[i];
      end
      prev_q      <= prev_d;
      out_q       <= out_d;
      head_q      <= head_d;
      tail_q      <= tail_d;
      count_q     <= count_d;
      phase_q     <= phase_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign out_valid = out_valid_q;
  assign out_data  = out_q;
endmodule

// ===== rtl/dls_link_setup.sv
`timescale 1ns/10ps
// What this block does
// - Zero to three doubling stages chosen by interpolation code 0..3.
// - Link parameters identical at device and transmitter.
// - Device supports modes 4,5,6,7,9,10 with their M,L,S,F.
// - A one in lane power-down mask powers that lane off.
// - Checksum method matches transmitter: fields or registers.
// - Field checksum: low byte of summed minus-one fields and flags.
// - Register checksum: low byte of sum of registers 0x450..0x45A.
module dls_link_setup (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic [3:0]  link_mode,
  input  wire logic [5:0]  k_minus_one,
  input  wire logic        scrambling,
  input  wire logic        subclass,
  input  wire logic [2:0]  link_version,
  input  wire logic        checksum_method,
  input  wire logic [6:0]  pll_feedback_count,
  input  wire logic [1:0]  interpolation_select,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  output logic             dac_valid,
  output logic [15:0]      dac_data,
  output logic [7:0]       first_lane_checksum,
  output logic [3:0]       lane_enable_mask,
  output logic [3:0]       lane_power_off_mask,
  output logic             high_density_flag,
  output logic [1:0]       link_m,
  output logic [2:0]       link_l,
  output logic [1:0]       link_s,
  output logic [2:0]       link_f,
  output logic             config_error
);
  logic [7:0]  vco_q, vco_d, ref_q, ref_d, lpd_q, lpd_d;
  logic [7:0]  cfg_q [dls_pkg::CFG_COUNT];
  logic [7:0]  cfg_d [dls_pkg::CFG_COUNT];
  logic [7:0]  rdata_q, rdata_d, cks_q, cks_d;
  logic [1:0]  m_v, s_v;
  logic [2:0]  l_v, f_v;
  logic        mode_ok, hd_v;
  logic [7:0]  sum_f, sum_r;
  logic        err_q, err_d;
  logic [3:0]  stage_v;
  logic [15:0] stage_data [4];
  logic [3:0]  stage_vld;

  // Mode table: {M, L, S, F}
  function automatic logic [10:0] mode_row(input logic [3:0] md);
    case (md)
      dls_pkg::DLS_MODE_4:  mode_row = {1'b1, 2'h2, 3'h4, 2'h1, 3'h1};
      dls_pkg::DLS_MODE_5:  mode_row = {1'b1, 2'h2, 3'h4, 2'h2, 3'h2};
      dls_pkg::DLS_MODE_6:  mode_row = {1'b1, 2'h2, 3'h2, 2'h1, 3'h2};
      dls_pkg::DLS_MODE_7:  mode_row = {1'b1, 2'h2, 3'h1, 2'h1, 3'h4};
      dls_pkg::DLS_MODE_9:  mode_row = {1'b1, 2'h1, 3'h2, 2'h1, 3'h1};
      dls_pkg::DLS_MODE_10: mode_row = {1'b1, 2'h1, 3'h1, 2'h1, 3'h2};
      default:              mode_row = 11'h000;
    endcase
  endfunction

  always_comb begin
    {mode_ok, m_v, l_v, s_v, f_v} = mode_row(link_mode);
    hd_v = (f_v == 3'h1);
  end

  // Field sum uses N-1 = Np-1 = 15 fixed
  always_comb begin
    sum_f = {5'h00, l_v - 3'h1} + {6'h00, m_v - 2'h1} + {2'h0, k_minus_one}
          + (dls_pkg::N_VALUE - 8'h01) + (dls_pkg::N_VALUE - 8'h01)
          + {6'h00, s_v - 2'h1} + {7'h00, scrambling} + {7'h00, hd_v}
          + {7'h00, subclass} + {5'h00, link_version};
    sum_r = 8'h00;
    for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
      sum_r = sum_r + cfg_q[i];
    end
  end

  always_comb begin
    vco_d   = vco_q;
    ref_d   = ref_q;
    lpd_d   = lpd_q;
    rdata_d = rdata_q;
    for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (reg_wr) begin
      if (reg_addr == dls_pkg::VCO_OUTPUT_DIVIDER_ADDR) vco_d = reg_wdata;
      if (reg_addr == dls_pkg::PLL_REFERENCE_DIVIDER_ADDR) ref_d = reg_wdata;
      if (reg_addr == dls_pkg::LANE_POWER_DOWN_MASK_ADDR) lpd_d = reg_wdata;
      for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
        if (reg_addr == dls_pkg::CFG_FIRST_ADDR + 12'(i)) cfg_d[i] = reg_wdata;
      end
    end
    if (reg_rd) begin
      rdata_d = 8'h00;
      if (reg_addr == dls_pkg::VCO_OUTPUT_DIVIDER_ADDR) rdata_d = vco_q;
      if (reg_addr == dls_pkg::PLL_REFERENCE_DIVIDER_ADDR) rdata_d = ref_q;
      if (reg_addr == dls_pkg::LANE_POWER_DOWN_MASK_ADDR) rdata_d = lpd_q;
      for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
        if (reg_addr == dls_pkg::CFG_FIRST_ADDR + 12'(i)) rdata_d = cfg_q[i];
      end
    end
    cks_d = (checksum_method == dls_pkg::CKSUM_REGS) ? sum_r : sum_f;
    // Host owns the ranges; device only flags what it can see
    err_d = !mode_ok
          || (pll_feedback_count < dls_pkg::FB_COUNT_MIN)
          || (vco_q[dls_pkg::VCO_DIV_W-1:0] == 2'h0)
          || (ref_q[dls_pkg::REF_DIV_W-1:0] == 3'h0)
          || (ref_q[dls_pkg::REF_DIV_W-1:0] > 3'h4)
          || (((link_mode == dls_pkg::DLS_MODE_4) || (link_mode == dls_pkg::DLS_MODE_9))
              && (k_minus_one != 6'h1F));
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_q   <= dls_pkg::VCO_DIV_RST;
      ref_q   <= dls_pkg::REF_DIV_RST;
      lpd_q   <= dls_pkg::LANE_PD_RST;
      rdata_q <= 8'h00;
      cks_q   <= 8'h00;
      err_q   <= 1'b0;
      for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else begin
      vco_q   <= vco_d;
      ref_q   <= ref_d;
      lpd_q   <= lpd_d;
      rdata_q <= rdata_d;
      cks_q   <= cks_d;
      err_q   <= err_d;
      for (int i = 0; i < dls_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // Stage k is live when code exceeds k; bypassed stages pass through
  assign stage_data[0] = sample_data;
  assign stage_vld[0]  = sample_valid;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      logic        ov;
      logic [15:0] od;
      dls_interp_stage u_stage (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (stage_vld[g]),
        .in_data   (stage_data[g]),
        .out_valid (ov),
        .out_data  (od)
      );
      assign stage_v[g]      = (interpolation_select > 2'(g));
      assign stage_vld[g+1]  = stage_v[g] ? ov : stage_vld[g];
      assign stage_data[g+1] = stage_v[g] ? od : stage_data[g];
    end
  endgenerate
  assign stage_v[3] = 1'b0;

  assign dac_valid           = stage_vld[3];
  assign dac_data            = stage_data[3];
  assign reg_rdata           = rdata_q;
  assign first_lane_checksum = cks_q;
  assign lane_enable_mask    = 4'((5'h01 << l_v) - 5'h01);
  assign lane_power_off_mask = lpd_q[dls_pkg::LANES-1:0];
  assign high_density_flag   = hd_v;
  assign link_m              = m_v;
  assign link_l              = l_v;
  assign link_s              = s_v;
  assign link_f              = f_v;
  assign config_error        = err_q;
endmodule

// ===== tb/dls_link_setup_asserts.sv
`timescale 1ns/10ps
module dls_link_setup_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [3:0]  link_mode,
  input wire logic [5:0]  k_minus_one,
  input wire logic [6:0]  pll_feedback_count,
  input wire logic [1:0]  interpolation_select,
  input wire logic        sample_valid,
  input wire logic [15:0] sample_data,
  input wire logic        dac_valid,
  input wire logic [15:0] dac_data,
  input wire logic [3:0]  lane_enable_mask,
  input wire logic [3:0]  lane_power_off_mask,
  input wire logic        high_density_flag,
  input wire logic [1:0]  link_m,
  input wire logic [2:0]  link_l,
  input wire logic [1:0]  link_s,
  input wire logic [2:0]  link_f,
  input wire logic        config_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_lane_mask: assert property (lane_enable_mask == (4'h1 << link_l) - 4'h1)
    else $error("lane enable mask does not match lane count");
  chk_hd_flag: assert property (high_density_flag == (link_f == 3'h1))
    else $error("high density flag wrong");
  chk_mode_five: assert property (link_mode == 4'h5 |->
    {link_m, link_l, link_s, link_f} == {2'h2, 3'h4, 2'h2, 3'h2})
    else $error("mode five parameters wrong");
  chk_pd_write: assert property (reg_wr && reg_addr == 12'h201 |=>
    {4'h0, lane_power_off_mask} == ($past(reg_wdata) & 8'h0F))
    else $error("lane power-off mask not updated");
  chk_unmapped_rd: assert property (reg_rd && reg_addr == 12'h300 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_bad_mode: assert property (link_mode == 4'h8 |=> config_error)
    else $error("unsupported mode not flagged");
  chk_k_rule: assert property (link_mode == 4'h4 && k_minus_one != 6'h1F |=> config_error)
    else $error("frame count rule not flagged");
  chk_fb_low: assert property (pll_feedback_count < 7'h06 |=> config_error)
    else $error("low feedback count not flagged");
  chk_bypass_path: assert property (interpolation_select == 2'h0 && sample_valid |->
    dac_valid && dac_data == sample_data)
    else $error("bypass sample not passed through");
  cover property (config_error);
  cover property (dac_valid && interpolation_select == 2'h3);
  cover property (reg_rd && reg_addr == 12'h201);
endmodule

bind dls_link_setup dls_link_setup_chk chk_i (.*);

// ===== tb/dls_tx_model.sv
`timescale 1ns/10ps
module dls_tx_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tx_en,
  input  wire logic [1:0] interpolation_select,
  output logic            sample_valid = 1'b0,
  output logic [15:0]     sample_data = 16'h0000
);
  logic [3:0] cnt_q = 4'h0;
  logic       fire;
  assign fire = rst_n && tx_en && cnt_q == 4'h0;
  always @(negedge sys_clk) begin
    // One sample per 2^code cycles keeps within the data rate limit
    cnt_q <= (rst_n && tx_en) ? (cnt_q + 4'h1) & ((4'h1 << interpolation_select) - 4'h1) : 4'h0;
    sample_valid <= fire;
    // Idle data toggles so a stale word never looks like a sample
    sample_data <= fire ? 16'($urandom) : ~sample_data;
  end
endmodule

// ===== tb/dls_link_setup_test.sv
`timescale 1ns/10ps
module dls_link_setup_test;
  logic        sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_en = 0;
  logic        scrambling = 0, subclass = 0, checksum_method = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, first_lane_checksum, sum;
  logic [3:0]  link_mode = 4'h4, lane_enable_mask, lane_power_off_mask;
  logic [5:0]  k_minus_one = 6'h1F;
  logic [2:0]  link_version = 0, link_l, link_f;
  logic [6:0]  pll_feedback_count = 7'h06;
  logic [1:0]  interpolation_select = 0, link_m, link_s;
  logic        sample_valid, dac_valid, high_density_flag, config_error;
  logic [15:0] sample_data, dac_data;
  int md[6] = '{4, 5, 6, 7, 9, 10}, mm[6] = '{2, 2, 2, 2, 1, 1};
  int ll[6] = '{4, 4, 2, 1, 2, 1}, ss[6] = '{1, 2, 1, 1, 1, 1}, ff[6] = '{1, 2, 2, 4, 1, 2};
  int failures = 0, n_compared = 0, outs = 0, i, j;
  dls_link_setup uut (.*);
  dls_tx_model tx (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (dac_valid === 1'b1) outs <= outs + 1;
  task chk(string nm, logic [15:0] got, int exp);
    n_compared++;
    if (got !== 16'(exp)) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, 16'(exp), got);
    end
  endtask
  task cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr(logic [11:0] a, logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task rd(logic [11:0] a, logic [7:0] e);
    reg_rd = 1;
    reg_addr = a;
    cyc(1);
    reg_rd = 0;
    chk("rdata", reg_rdata, e);
    cyc(1);
  endtask
  task cfg(logic [7:0] v, logic [7:0] r, logic [6:0] fb, logic [3:0] m, int e);
    wr(12'h08B, v);
    wr(12'h08C, r);
    pll_feedback_count = fb;
    link_mode = m;
    cyc(2);
    chk("config_error", config_error, e);
  endtask
  // N-1 and Np-1 are 15 each; the three minus-ones leave 27
  function int fsum(int n);
    return (ll[n] + mm[n] + ss[n] + k_minus_one + 27 + scrambling + (ff[n] == 1)
            + subclass + link_version) % 256;
  endfunction
  task close_out;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    failures++;
    close_out;
  end
  initial begin
    i = $urandom(32'h6BD2ECF7);
    cyc(2);
    rst_n = 1;
    rd(12'h08B, 8'h00);
    rd(12'h08C, 8'h00);
    rd(12'h201, 8'h00);
    wr(12'h201, 8'h0A);
    chk("power_off", lane_power_off_mask, 4'hA);
    rd(12'h201, 8'h0A);
    wr(12'h300, 8'h5A);
    rd(12'h300, 8'h00);
    wr(12'h08B, 8'h01);
    wr(12'h08C, 8'h01);
    for (i = 0; i < 6; i++) begin
      link_mode = md[i][3:0];
      k_minus_one = i[0] ? 6'h1F : 6'h0F;
      {scrambling, subclass, link_version} = 5'($urandom);
      cyc(2);
      chk("m", link_m, mm[i]);
      chk("l", link_l, ll[i]);
      chk("s", link_s, ss[i]);
      chk("f", link_f, ff[i]);
      chk("hd", high_density_flag, ff[i] == 1);
      chk("lanes", lane_enable_mask, (1 << ll[i]) - 1);
      chk("fsum", first_lane_checksum, fsum(i));
      chk("k_err", config_error, k_minus_one != 31 && md[i] % 5 == 4);
    end
    sum = 0;
    for (i = 0; i < 11; i++) begin
      j = $urandom;
      wr(12'(12'h450 + i), j[7:0]);
      rd(12'(12'h450 + i), j[7:0]);
      sum += j[7:0];
    end
    checksum_method = 1;
    cyc(2);
    chk("rsum", first_lane_checksum, sum);
    checksum_method = 0;
    k_minus_one = 6'h1F;
    cfg(8'h01, 8'h01, 7'h06, 4'h4, 0);
    cfg(8'h01, 8'h01, 7'h05, 4'h4, 1);
    cfg(8'h00, 8'h01, 7'h7F, 4'h9, 1);
    cfg(8'h03, 8'h04, 7'h7F, 4'h9, 0);
    cfg(8'h02, 8'h05, 7'h06, 4'h5, 1);
    cfg(8'h02, 8'h00, 7'h06, 4'h5, 1);
    cfg(8'h01, 8'h01, 7'h06, 4'h8, 1);
    chk("unsup", {link_m, link_l, link_s, link_f}, 0);
    for (i = 0; i < 4; i++) begin
      interpolation_select = i[1:0];
      outs = 0;
      tx_en = 1;
      cyc(8 << i);
      tx_en = 0;
      // Three queued stages need up to about fourteen cycles to drain
      cyc(20);
      chk("outputs", outs, 8 << i);
    end
    close_out;
  end
endmodule
